// [common/gate_drive_pkg.sv]
// Package: timing constants and phase states of the push-pull gate drive
package gate_drive_pkg;

	// Core clock
	localparam int unsigned CLK_PERIOD_PS = 4000;              // 250 MHz

	// Supply selection encoding
	localparam logic SUPPLY_3V3 = 1'b0;
	localparam logic SUPPLY_5V0 = 1'b1;

	// Dead interval, printed figures in ns
	localparam int unsigned DEAD_3V3_NS = 150;
	localparam int unsigned DEAD_5V0_NS = 50;
	// Least time: round up to whole cycles
	localparam int unsigned DEAD_3V3_CYC = (DEAD_3V3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DEAD_5V0_CYC = (DEAD_5V0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Switching rates in kHz: nominal start-up and operating rates, then range limits
	localparam int unsigned STARTUP_RATE_KHZ = 300;
	localparam int unsigned RATE_3V3_KHZ     = 360;
	localparam int unsigned RATE_5V0_KHZ     = 410;
	localparam int unsigned RATE_MIN_3V3_KHZ = 250;
	localparam int unsigned RATE_MAX_3V3_KHZ = 550;
	localparam int unsigned RATE_MAX_5V0_KHZ = 620;

	// Half period of the drain waveform in clock cycles: f_clk / (2 * rate)
	localparam int unsigned HALF_STARTUP_CYC = 250000 / (2 * STARTUP_RATE_KHZ);
	localparam int unsigned HALF_3V3_CYC     = 250000 / (2 * RATE_3V3_KHZ);
	localparam int unsigned HALF_5V0_CYC     = 250000 / (2 * RATE_5V0_KHZ);

	// Start-up phase length in drain periods before the nominal rate applies
	localparam int unsigned STARTUP_PERIODS = 16;

	// Counter widths
	localparam int unsigned CNT_W = 10;
	localparam int unsigned ST_W  = 5;

	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	localparam logic [ST_W-1:0]  ST_ZERO  = 5'h00;

	// Output stage states
	typedef enum logic [1:0] {
		DRV_IDLE = 2'b00,
		DRV_A    = 2'b01,
		DRV_DEAD = 2'b10,
		DRV_B    = 2'b11
	} drv_state_t;

endpackage : gate_drive_pkg

// [hw/phase_divider.sv]
// Divider that turns the oscillator tick stream into a complementary 50% phase pair
`timescale 1ns/100ps
module phase_divider
	import gate_drive_pkg::*;
(
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic             clk_en,
	// Control
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] half_cyc,
	// Phase pair
	output logic                  phase_s,
	output logic                  phase_s_n,
	output logic                  toggle
);
	import gate_drive_pkg::*;

	logic [CNT_W-1:0] cnt_q;
	logic             ph_q;
	logic             wrap;

	// Terminal count marks the half-period boundary
	assign wrap      = run && (cnt_q >= half_cyc - 10'h001);
	assign phase_s   = ph_q;
	assign phase_s_n = ~ph_q;
	assign toggle    = wrap;

	// Equal halves give 50% duty on each phase
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= CNT_ZERO;
			ph_q  <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				cnt_q <= CNT_ZERO;
				ph_q  <= 1'b0;
			end else if (wrap) begin
				cnt_q <= CNT_ZERO;
				ph_q  <= ~ph_q;
			end else begin
				cnt_q <= cnt_q + 10'h001;
			end
		end
	end

endmodule : phase_divider

// [hw/push_pull_gate_drive_dead_time.sv]
// Push-pull gate drive: divider, dead-time logic and open-drain output stage
// Notes on behaviour
// - Divider yields two complementary phases, each high half the period.
// - Oscillator feeds divider then dead-time logic; outputs drive both transistors.
// - Both output switches conduct alternately, each transformer half every cycle.
// - After each high pulse both gates low before the other rises.
// - Dead interval about 150 ns at 3.3 V, 50 ns at 5 V.
// - Switching rate 250-550 kHz at 3.3 V, 300-620 kHz at 5 V.
// - Switching starts near 300 kHz as supply comes up.
// - With supply removed both drains are high impedance.
`timescale 1ns/100ps
module push_pull_gate_drive_dead_time
	import gate_drive_pkg::*;
(
	// Clock, reset and enable
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic clk_en,
	// Supply status pins
	input  wire logic supply_ok,
	input  wire logic supply_sel,
	// Gate controls
	output logic      gate_a,
	output logic      gate_b,
	// Open-drain drains, enable low while pulling low
	output logic      drain_out_a,
	output logic      drain_out_a_oe_n,
	output logic      drain_out_b,
	output logic      drain_out_b_oe_n
);
	import gate_drive_pkg::*;

	// Cycle count of the dead interval for the selected supply
	function automatic logic [CNT_W-1:0] dead_cycles(input logic sel);
		dead_cycles = (sel == SUPPLY_5V0) ? CNT_W'(DEAD_5V0_CYC) : CNT_W'(DEAD_3V3_CYC);
	endfunction : dead_cycles

	// Half period in cycles: start-up rate first, then the selected supply's rate
	function automatic logic [CNT_W-1:0] half_cycles(input logic early, input logic sel);
		if (early) begin
			half_cycles = CNT_W'(HALF_STARTUP_CYC);
		end else if (sel == SUPPLY_5V0) begin
			half_cycles = CNT_W'(HALF_5V0_CYC);
		end else begin
			half_cycles = CNT_W'(HALF_3V3_CYC);
		end
	endfunction : half_cycles

	// Pin synchronisers: the pins are asynchronous to mclk, so nothing but the
	// second stage is read; the first stage may still be settling
	logic ok_s1_q, ok_s2_q;
	logic sel_s1_q, sel_s2_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ok_s1_q  <= 1'b0;
			ok_s2_q  <= 1'b0;
			sel_s1_q <= 1'b0;
			sel_s2_q <= 1'b0;
		end else if (clk_en) begin
			ok_s1_q  <= supply_ok;
			ok_s2_q  <= ok_s1_q;
			sel_s1_q <= supply_sel;
			sel_s2_q <= sel_s1_q;
		end
	end

	// Start-up tracking: count drain periods at the start-up rate
	logic [ST_W-1:0] st_cnt_q;
	logic            started_q;
	logic            run;
	logic            toggle;
	logic            phase_s;
	logic            phase_s_n;
	logic [CNT_W-1:0] half_cyc;
	logic [CNT_W-1:0] dead_len;
	logic             sel_run_q;

	// The sequence only runs while the supply is seen present
	assign run = ok_s2_q;
	// Start at 300 kHz, then settle at the supply's nominal rate
	assign half_cyc = half_cycles(!started_q, sel_run_q);
	assign dead_len = dead_cycles(sel_run_q);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_cnt_q  <= ST_ZERO;
			started_q <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				st_cnt_q  <= ST_ZERO;
				started_q <= 1'b0;
			end else if (toggle && phase_s && !started_q) begin
				st_cnt_q  <= st_cnt_q + 5'h01;
				started_q <= (st_cnt_q == ST_W'(STARTUP_PERIODS - 1));
			end
		end
	end

	// Divider producing the complementary phase pair
	phase_divider u_div (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.clk_en    (clk_en),
		.run       (run),
		.half_cyc  (half_cyc),
		.phase_s   (phase_s),
		.phase_s_n (phase_s_n),
		.toggle    (toggle)
	);

	// Dead-time logic: the gate of the new phase waits out the dead interval.
	// IDLE holds both gates off, DEAD counts the gap, A and B follow the divider
	// phase and drop as soon as it turns, so every gap but the first after IDLE trails a falling gate
	drv_state_t       state_q, state_d;
	logic [CNT_W-1:0] dead_q, dead_d;
	logic             dead_done;

	assign dead_done = (dead_q >= dead_len - 10'h001);

	always_comb begin
		state_d = state_q;
		dead_d  = CNT_ZERO;
		unique case (state_q)
			DRV_IDLE: begin
				if (run) state_d = DRV_DEAD;
			end
			DRV_A: begin
				if (!run || !phase_s) state_d = DRV_DEAD;
			end
			DRV_B: begin
				if (!run || !phase_s_n) state_d = DRV_DEAD;
			end
			DRV_DEAD: begin
				dead_d = dead_q + 10'h001;
				if (!run) begin
					state_d = DRV_IDLE;
				end else if (dead_done) begin
					// Always honour the divider phase so widths stay balanced
					state_d = phase_s ? DRV_A : DRV_B;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q     <= DRV_IDLE;
			dead_q      <= CNT_ZERO;
		end else if (clk_en) begin
			state_q     <= state_d;
			dead_q      <= dead_d;
		end
	end

	// Supply choice is taken while idle and held for the whole run: a select pin that
	// moves mid-run cannot give the two halves of a period different lengths
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sel_run_q <= SUPPLY_3V3;
		end else if (clk_en) begin
			if (state_q == DRV_IDLE) begin
				sel_run_q <= sel_s2_q;
			end
		end
	end

	// Second, independent break-before-make lock on the registered gates: it counts
	// cycles with both gates low, and a gate may only rise once the dead interval has
	// gone by, even if a fault ever let the sequencer skip its dead state
	logic [CNT_W-1:0] off_q;
	logic             off_ok;

	assign off_ok = (off_q >= dead_len - 10'h001);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			off_q <= CNT_ZERO;
		end else if (clk_en) begin
			if (gate_a || gate_b) begin
				off_q <= CNT_ZERO;
			end else if (off_q != 10'h3FF) begin
				off_q <= off_q + 10'h001;
			end
		end
	end

	// Registered gates; the states are exclusive and the guard adds a second lock,
	// so a gate rises only while the other is low and the dead interval is over
	logic gate_a_d, gate_b_d;
	assign gate_a_d = (state_d == DRV_A) && !gate_b && (gate_a || off_ok);
	assign gate_b_d = (state_d == DRV_B) && !gate_a && (gate_b || off_ok);

	// Gate controls; low through reset and whenever the sequence is idle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gate_a <= 1'b0;
			gate_b <= 1'b0;
		end else if (clk_en) begin
			gate_a <= gate_a_d;
			gate_b <= gate_b_d;
		end
	end

	// Open-drain stage: the data bit is always low and the enable alone switches the
	// drain; an enable high leaves the drain floating, also the state after reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			drain_out_a      <= 1'b0;
			drain_out_a_oe_n <= 1'b1;
			drain_out_b      <= 1'b0;
			drain_out_b_oe_n <= 1'b1;
		end else if (clk_en) begin
			drain_out_a      <= 1'b0;
			drain_out_a_oe_n <= ~gate_a_d;
			drain_out_b      <= 1'b0;
			drain_out_b_oe_n <= ~gate_b_d;
		end
	end

endmodule : push_pull_gate_drive_dead_time

// [dv/primary_model.sv]
// Centre-tapped primary seen from the two open-drain switches
`timescale 1ns/100ps
module primary_model (
	// Switch enables, low while conducting
	input  wire logic oe_a_n,
	input  wire logic oe_b_n,
	// Winding ends and overlap flag
	output logic      end_a,
	output logic      end_b,
	output logic      shorted
);
	// A released end flies above the tap, so it reads high
	assign end_a   = oe_a_n;
	assign end_b   = oe_b_n;
	// Both switches on would short the primary
	assign shorted = !oe_a_n && !oe_b_n;
endmodule : primary_model

// [dv/gate_drive_sva.sv]
// Checker: timing relations of the gate drive outputs
`timescale 1ns/100ps
module gate_drive_sva
	import gate_drive_pkg::*;
(
	// Clock, reset and inputs
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic supply_ok,
	input wire logic supply_sel,
	// Outputs
	input wire logic gate_a,
	input wire logic gate_b,
	input wire logic drain_out_a,
	input wire logic drain_out_a_oe_n,
	input wire logic drain_out_b,
	input wire logic drain_out_b_oe_n
);
	import gate_drive_pkg::*;

	logic [9:0] gap_q;
	logic       last_a_q;
	int         dead;
	assign dead = supply_sel ? DEAD_5V0_CYC : DEAD_3V3_CYC;
	// Both-low run length and which gate led last; first pulse belongs to b
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gap_q    <= 10'h000;
			last_a_q <= 1'b1;
		end else if (clk_en) begin
			gap_q    <= (gate_a | gate_b) ? 10'h000 : gap_q + {9'h000, gap_q != 10'h3FF};
			last_a_q <= gate_a | (last_a_q & !gate_b);
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_no_overlap: assert property (!(gate_a && gate_b)) else $error("gates overlap");
	a_oe_a_follows: assert property (drain_out_a_oe_n == !gate_a) else $error("enable a wrong");
	a_oe_b_follows: assert property (drain_out_b_oe_n == !gate_b) else $error("enable b wrong");
	a_drain_pull_low: assert property (!drain_out_a && !drain_out_b) else $error("drain data high");
	a_dead_gap: assert property ($rose(gate_a) || $rose(gate_b) |-> gap_q >= dead) else $error("gap short");
	a_alt_order_a: assert property ($rose(gate_a) |-> !last_a_q) else $error("a twice");
	a_alt_order_b: assert property ($rose(gate_b) |-> last_a_q) else $error("b twice");
	a_off_release: assert property ($fell(supply_ok) && clk_en |-> ##[1:6]
		(drain_out_a_oe_n && drain_out_b_oe_n && !gate_a && !gate_b)) else $error("no off mode");
	a_start_hold: assert property ($rose(supply_ok) |-> (!gate_a && !gate_b) [*3]) else $error("early gate");
	a_freeze_hold: assert property (!clk_en |=> $stable(gate_a) && $stable(gate_b)) else $error("moved");
endmodule : gate_drive_sva
bind push_pull_gate_drive_dead_time gate_drive_sva u_sva (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
	.supply_ok(supply_ok), .supply_sel(supply_sel), .gate_a(gate_a), .gate_b(gate_b),
	.drain_out_a(drain_out_a), .drain_out_a_oe_n(drain_out_a_oe_n),
	.drain_out_b(drain_out_b), .drain_out_b_oe_n(drain_out_b_oe_n));

// [dv/push_pull_gate_drive_dead_time_tb.sv]
// Testbench: gate order, dead gap, rates, freeze and off mode
`timescale 1ns/100ps
module push_pull_gate_drive_dead_time_tb;
	import gate_drive_pkg::*;
	localparam int LIMIT = 3000;
	logic mclk, arst_n, clk_en, supply_ok, supply_sel;
	logic gate_a, gate_b, da_o, da_oe_n, db_o, db_oe_n, end_a, end_b, shorted;
	int   failures = 0, compares = 0, min_gap, gap;

	push_pull_gate_drive_dead_time dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
		.supply_ok(supply_ok), .supply_sel(supply_sel), .gate_a(gate_a), .gate_b(gate_b),
		.drain_out_a(da_o), .drain_out_a_oe_n(da_oe_n), .drain_out_b(db_o), .drain_out_b_oe_n(db_oe_n));
	primary_model u_pri (.oe_a_n(da_oe_n), .oe_b_n(db_oe_n), .end_a(end_a), .end_b(end_b), .shorted(shorted));

	// 250 MHz clock
	initial begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		if (failures == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	// Shortest both-low stretch ahead of a rise; the primary must never see both on
	always @(posedge mclk) begin
		if (gate_a | gate_b) begin
			if (gap > 0 && gap < min_gap) min_gap = gap;
			gap = 0;
		end else gap = gap + 1;
	end
	always @(negedge mclk) if (arst_n === 1'b1) check(shorted, 0);

	// Bounded wait for the next rise of one gate; n returns the cycles spent
	task automatic wait_rise(input bit on_a, output int n);
		n = 0;
		do begin @(negedge mclk); n++; end while ((on_a ? gate_a : gate_b) !== 1'b0 && n < LIMIT);
		do begin @(negedge mclk); n++; end while ((on_a ? gate_a : gate_b) !== 1'b1 && n < LIMIT);
		if (n >= LIMIT) begin
			failures++;
			give_verdict();
		end
	endtask : wait_rise

	// Full power cycle at one supply: reset, start-up, nominal run, freeze, off
	task automatic run_supply(input logic sel);
		int n, n1, n2, dead;
		logic [1:0] held;
		dead = sel ? DEAD_5V0_CYC : DEAD_3V3_CYC;
		arst_n = 0;
		supply_ok = 0;
		supply_sel = sel;
		repeat (6) @(negedge mclk);
		check({gate_a, gate_b, da_oe_n, db_oe_n}, 4'h3);
		arst_n = 1;
		repeat (4) @(negedge mclk);
		check({gate_a, gate_b, da_oe_n, db_oe_n}, 4'h3);
		supply_ok = 1;
		min_gap = LIMIT;
		wait_rise(0, n);
		check(n, 3 + dead);
		check(gate_a, 0);
		wait_rise(1, n);
		check(n inside {[HALF_STARTUP_CYC-2:HALF_STARTUP_CYC+2]}, 1);
		check({end_a, end_b}, 2'h1);
		repeat (STARTUP_PERIODS + 2) wait_rise(1, n);
		wait_rise(0, n1);
		wait_rise(1, n2);
		check(n1 - n2 inside {[-1:1]}, 1);
		check(n1 + n2 inside {[250000 / (sel ? 620 : 550):250000 / (sel ? 300 : 250)]}, 1);
		check(min_gap inside {[dead:dead+4]}, 1);
		clk_en = 0;
		held = {gate_a, gate_b};
		repeat (40) @(negedge mclk);
		check({gate_a, gate_b}, held);
		clk_en = 1;
		supply_ok = 0;
		repeat (8) @(negedge mclk);
		check({gate_a, gate_b, da_oe_n, db_oe_n, end_a, end_b}, 6'h0F);
		check({da_o, db_o}, 2'h0);
	endtask : run_supply

	initial begin
		arst_n = 0;
		clk_en = 1;
		supply_ok = 0;
		supply_sel = SUPPLY_3V3;
		gap = 0;
		min_gap = LIMIT;
		run_supply(SUPPLY_3V3);
		run_supply(SUPPLY_5V0);
		give_verdict();
	end
endmodule : push_pull_gate_drive_dead_time_tb
